// ===== coherent_line_gmp_framer.sv
// Purpose: builds and parses a four-lane interleaved line frame with stuffing
// Assumes: host and line blocks are on the clock domain; tick rate set by LINE_DIV
// Notes:   lane n of the line carries the tributary named by its slot id byte; block 0 of each lane is row 1 start
// Overview of operation
// R01: frame is 128 rows of 20 blocks
// R02: four 120-bit lane markers lead row one
// R03: pad then 320-bit overhead follow markers
// R04: five pad bits align payload to blocks
// R05: five header blocks, 2555 payload blocks
// R06: slot id byte at overhead row 4 byte 5
// R07: each host port tied to its slot id
// R08: receiver uses lowest-ordinal lane counts only
// R09: port lanes ordered by time, gaps allowed
// R10: slot id example values per mode
// R11: wider frames slice header by tributary
// R12: up to four hosts interleaved per block
// R13: hosts stay within 100 ppm
// R14: stuff blocks carry all zeros
// R15: 10220 mapping blocks per four frames
// R16: counts renewed once per four frames
// R17: bytes one to three: count, flags, check
// R18: bytes four to six: residual and check
// R19: frame timed by local tick, clients stuffed
// R20: receiver checks counts and recovers data
// R21: overhead fields and degrade bits handled
// R22: fault reflect, local fault, pattern test
// R23: counts govern the following four-frame set
// R24: eight-bit check polynomial x8+x2+x+1
// R25: sigma-delta spreads stuff blocks evenly
`timescale 1ns/1ns
module coherent_line_gmp_framer #(
	parameter logic [7:0] LINE_DIV = 8'h01
) (
	input  logic              clock,
	input  logic              sys_rst,
	input  logic [7:0]        paddr,
	input  logic              psel,
	input  logic              penable,
	input  logic              pwrite,
	input  logic [31:0]       pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  logic [3:0][256:0] tx_data,
	input  logic [3:0]        tx_valid,
	output logic [3:0]        tx_ready,
	output logic [256:0]      line_data,
	output logic              line_valid,
	output logic              line_sof,
	input  logic [256:0]      rx_line_data,
	input  logic              rx_line_valid,
	input  logic              rx_line_sof,
	input  logic              fec_degrade,
	output logic [3:0][256:0] rx_data,
	output logic [3:0]        rx_valid
);
	localparam int HB = framer_pkg::HDR_BITS;

	typedef struct packed {
		logic [7:0]        tick_cnt;
		logic [31:0]       ctrl;
		logic [31:0]       msi_cfg;
		logic [6:0]        cnd_cfg;
		logic [1:0]        tx_lane;
		logic [4:0]        tx_blk;
		logic [6:0]        tx_row;
		logic [7:0]        tx_multiframe_alignment_byte;
		logic [3:0][13:0]  tx_acc;
		logic [3:0][13:0]  tx_meas;
		logic [3:0][13:0]  tx_cm_cur;
		logic [3:0][13:0]  tx_cm_nxt;
		logic [256:0]      line_data;
		logic              line_valid;
		logic              line_sof;
		logic [30:0]       prbs_tx;
		logic [30:0]       prbs_rx;
		logic [15:0]       prbs_err;
		logic              rx_sync;
		logic [1:0]        rx_lane;
		logic [4:0]        rx_blk;
		logic [6:0]        rx_row;
		logic [7:0]        rx_multiframe_alignment_byte;
		logic [3:0][256:0] rx_blk3;
		logic [3:0][13:0]  rx_cm_nxt;
		logic [3:0][13:0]  rx_cm_cur;
		logic [3:0][13:0]  rx_acc;
		logic [3:0][6:0]   rx_cnd_nxt;
		logic [3:0][6:0]   rx_cnd_cur;
		logic [3:0]        rx_crc_bad;
		logic [3:0][7:0]   rx_msi;
		logic              rx_far_ld;
		logic              rx_far_flt;
		logic [3:0][256:0] rx_data;
		logic [3:0]        rx_valid;
		logic [31:0]       prdata;
		logic              perr;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// sigma-delta step: msb set when this mapping block carries data
	function automatic logic [14:0] gmp_step(input logic [13:0] acc, input logic [13:0] cm);
		logic [14:0] sum;
		logic [14:0] dif;
		sum = {1'b0, acc} + {1'b0, cm};
		dif = sum - {1'b0, framer_pkg::PMS};
		if (sum >= {1'b0, framer_pkg::PMS}) begin
			gmp_step = {1'b1, dif[13:0]};
		end else begin
			gmp_step = {1'b0, sum[13:0]};
		end
	endfunction

	// lowest-ordinal lane whose slot id names this port
	function automatic logic [1:0] first_lane(input logic [31:0] media_slot_id_byte, input logic [1:0] port);
		logic [1:0] fl;
		fl = 2'b00;
		for (int i = 3; i >= 0; i--) begin
			if (media_slot_id_byte[8 * i +: 2] == port) begin
				fl = 2'(i);
			end
		end
		first_lane = fl;
	endfunction

	// x31+x28+1, first output bit in bit 0; state returned above the block
	function automatic logic [287:0] prbs_block(input logic [30:0] seed);
		logic [30:0]  s;
		logic [256:0] b;
		s = seed;
		b = '0;
		for (int i = 0; i < framer_pkg::BLK_W; i++) begin
			b[i] = s[30] ^ s[27];
			s = {s[29:0], b[i]};
		end
		prbs_block = {s, b};
	endfunction

	function automatic logic [30:0] prbs_seed(input logic [256:0] b);
		logic [30:0] s;
		s = '0;
		for (int k = 0; k < 31; k++) begin
			s[k] = b[256 - k];
		end
		prbs_seed = s;
	endfunction

	function automatic logic [HB-1:0] put_byte(input logic [HB-1:0] h, input int idx,
		input logic [7:0] v);
		logic [HB-1:0] r;
		r = h;
		for (int k = 0; k < 8; k++) begin
			r[framer_pkg::OH_START + 8 * idx + k] = v[7 - k];
		end
		put_byte = r;
	endfunction

	function automatic logic [7:0] get_byte(input logic [513:0] oh, input int idx);
		logic [7:0] v;
		v = '0;
		for (int k = 0; k < 8; k++) begin
			v[7 - k] = oh[framer_pkg::ROH_OFS + 8 * idx + k];
		end
		get_byte = v;
	endfunction

	logic          tick;
	logic          tx_go;
	logic          tx_pay;
	logic          tx_prbs;
	logic [1:0]    tx_port;
	logic [1:0]    tx_fl;
	logic [14:0]   tx_step;
	logic [13:0]   jc_cm;
	logic          jc_inc;
	logic          jc_dec;
	logic [7:0]    tx_crc8;
	logic [3:0]    tx_crc4;
	logic [7:0]    tx_stat;
	logic [HB-1:0] tx_hdr;
	logic [287:0]  prbs_gen_v;
	logic [287:0]  prbs_chk_v;
	logic [1:0]    rx_lane_c;
	logic [4:0]    rx_blk_c;
	logic [6:0]    rx_row_c;
	logic          rx_pay;
	logic [513:0]  rx_oh;
	logic [7:0]    rx_jc1;
	logic [7:0]    rx_jc2;
	logic [7:0]    rx_jc4;
	logic [7:0]    rx_crc8;
	logic [3:0]    rx_crc4;
	logic [1:0]    rx_port;
	logic [1:0]    rx_fl;
	logic [14:0]   rx_step;

	assign tick       = st_reg.tick_cnt == LINE_DIV - 8'h01; // [R19]
	assign tx_go      = tick & st_reg.ctrl[framer_pkg::CTRL_TX_EN];
	assign tx_prbs    = st_reg.ctrl[framer_pkg::CTRL_PRBS_GEN];
	assign tx_port    = st_reg.msi_cfg[{st_reg.tx_lane, 3'b000} +: 2]; // [R07]
	assign tx_fl      = first_lane(st_reg.msi_cfg, tx_port);
	assign tx_pay     = !(st_reg.tx_row == 7'd0 && 32'(st_reg.tx_blk) < framer_pkg::HDR_BLKS);
	assign tx_step    = gmp_step(st_reg.tx_acc[st_reg.tx_lane], st_reg.tx_cm_cur[tx_fl]);
	assign jc_cm      = st_reg.tx_cm_nxt[tx_fl];
	assign jc_inc     = jc_cm > st_reg.tx_cm_cur[tx_fl];
	assign jc_dec     = jc_cm < st_reg.tx_cm_cur[tx_fl];
	assign prbs_gen_v = prbs_block(st_reg.prbs_tx);
	assign prbs_chk_v = prbs_block(st_reg.prbs_rx);
	assign tx_stat    = {st_reg.ctrl[framer_pkg::CTRL_LD] | fec_degrade, st_reg.rx_far_ld,
		(|st_reg.rx_crc_bad) | !st_reg.rx_sync, 5'b00000}; // [R21] [R22]

	jc_crc_unit tx_crc (
		.cm_field  ({jc_cm, jc_inc, jc_dec}),
		.cnd_field (st_reg.cnd_cfg),
		.crc8_out  (tx_crc8),
		.crc4_out  (tx_crc4)
	);

	// header of the lane now on the line: markers, pad, overhead, extra pad
	always_comb begin
		logic [HB-1:0] h;
		logic [1:0]    la;
		h = '0;
		la = 2'b00;
		for (int a = 0; a < framer_pkg::AM_MARKERS; a++) begin
			la = 2'(a);
			h[a * framer_pkg::AM_BITS +: framer_pkg::AM_BITS] =
				{framer_pkg::AM_PATTERN[119:2], framer_pkg::AM_PATTERN[1:0] ^ la}; // [R02]
		end
		h = put_byte(h, framer_pkg::OHB_MULTIFRAME_ALIGNMENT_BYTE, st_reg.tx_multiframe_alignment_byte); // [R21]
		h = put_byte(h, framer_pkg::OHB_STAT, tx_stat);
		h = put_byte(h, framer_pkg::OHB_GID, st_reg.ctrl[framer_pkg::CTRL_GID_LSB +: 8]);
		h = put_byte(h, framer_pkg::OHB_PID, {6'b000000, tx_port});
		h = put_byte(h, framer_pkg::OHB_MSI, st_reg.msi_cfg[{st_reg.tx_lane, 3'b000} +: 8]); // [R06] [R10]
		h = put_byte(h, framer_pkg::OHB_JC1, jc_cm[13:6]); // [R17]
		h = put_byte(h, framer_pkg::OHB_JC2, {jc_cm[5:0], jc_inc, jc_dec});
		h = put_byte(h, framer_pkg::OHB_JC3, tx_crc8);
		h = put_byte(h, framer_pkg::OHB_JC4, {st_reg.cnd_cfg, 1'b0}); // [R18]
		h = put_byte(h, framer_pkg::OHB_JC5, {tx_crc4, 4'h0});
		h = put_byte(h, framer_pkg::OHB_JC6, 8'h00);
		tx_hdr = h; // [R03] [R04]
	end

	always_comb begin
		for (int p = 0; p < framer_pkg::LANES; p++) begin
			tx_ready[p] = tx_go & tx_pay & tx_step[14] & !tx_prbs & (tx_port == 2'(p)); // [R12]
		end
	end

	// receive side position and overhead decode
	assign rx_lane_c = rx_line_sof ? 2'b00 : st_reg.rx_lane;
	assign rx_blk_c  = rx_line_sof ? 5'd0 : st_reg.rx_blk;
	assign rx_row_c  = rx_line_sof ? 7'd0 : st_reg.rx_row;
	assign rx_pay    = !(rx_row_c == 7'd0 && 32'(rx_blk_c) < framer_pkg::HDR_BLKS);
	assign rx_oh     = {rx_line_data, st_reg.rx_blk3[rx_lane_c]};
	assign rx_jc1    = get_byte(rx_oh, framer_pkg::OHB_JC1);
	assign rx_jc2    = get_byte(rx_oh, framer_pkg::OHB_JC2);
	assign rx_jc4    = get_byte(rx_oh, framer_pkg::OHB_JC4);
	assign rx_port   = st_reg.rx_msi[rx_lane_c][1:0];
	assign rx_fl     = first_lane(st_reg.rx_msi, rx_port); // [R08]
	assign rx_step   = gmp_step(st_reg.rx_acc[rx_lane_c], st_reg.rx_cm_cur[rx_fl]);

	jc_crc_unit rx_crc (
		.cm_field  ({rx_jc1, rx_jc2}),
		.cnd_field (rx_jc4[7:1]),
		.crc8_out  (rx_crc8),
		.crc4_out  (rx_crc4)
	);

	always_comb begin
		logic [7:0] wa;
		st_next = st_reg;
		wa = paddr;
		st_next.tick_cnt = tick ? 8'h00 : st_reg.tick_cnt + 8'h01;

		// register bus: decode in setup, act in access
		if (psel && !penable) begin
			st_next.perr = 1'b0;
			st_next.prdata = 32'h0000_0000;
			if (wa[1:0] != 2'b00) begin
				st_next.perr = 1'b1;
			end else if (wa[7:4] == framer_pkg::REG_RX_CM_HI) begin
				st_next.prdata = {9'h000, st_reg.rx_cnd_cur[wa[3:2]], 2'b00,
					st_reg.rx_cm_cur[wa[3:2]]};
			end else if (wa[7:4] == framer_pkg::REG_TX_CM_HI) begin
				st_next.prdata = {18'h00000, st_reg.tx_cm_cur[wa[3:2]]};
			end else begin
				case (wa)
					framer_pkg::REG_CTRL:     st_next.prdata = st_reg.ctrl;
					framer_pkg::REG_MSI_CFG:  st_next.prdata = st_reg.msi_cfg;
					framer_pkg::REG_CND_CFG:  st_next.prdata = {25'h0000000, st_reg.cnd_cfg};
					framer_pkg::REG_STATUS:   st_next.prdata = {16'h0000, st_reg.rx_multiframe_alignment_byte, 1'b0,
						st_reg.rx_far_flt, st_reg.rx_far_ld, st_reg.rx_sync, st_reg.rx_crc_bad};
					framer_pkg::REG_RX_MSI:   st_next.prdata = st_reg.rx_msi;
					framer_pkg::REG_PRBS_ERR: st_next.prdata = {16'h0000, st_reg.prbs_err};
					default:                  st_next.perr = 1'b1;
				endcase
			end
		end
		if (psel && penable && pwrite) begin
			case (wa)
				framer_pkg::REG_CTRL:     st_next.ctrl = pwdata;
				framer_pkg::REG_MSI_CFG:  st_next.msi_cfg = pwdata;
				framer_pkg::REG_CND_CFG:  st_next.cnd_cfg = pwdata[6:0];
				framer_pkg::REG_PRBS_ERR: st_next.prbs_err = 16'h0000;
				default:                  st_next.perr = st_reg.perr;
			endcase
		end

		// transmit: one block of the current lane per tick
		st_next.line_valid = tx_go;
		st_next.line_sof = tx_go && st_reg.tx_lane == 2'b00 && st_reg.tx_blk == 5'd0
			&& st_reg.tx_row == 7'd0;
		if (tx_go) begin
			if (!tx_pay) begin
				st_next.line_data = tx_hdr[32'(st_reg.tx_blk) * framer_pkg::BLK_W +: 257]; // [R05]
			end else begin
				st_next.tx_acc[st_reg.tx_lane] = tx_step[13:0]; // [R25]
				if (tx_prbs) begin
					st_next.line_data = prbs_gen_v[256:0]; // [R22]
					st_next.prbs_tx = prbs_gen_v[287:257];
				end else if (!tx_step[14]) begin
					st_next.line_data = '0; // [R14]
				end else if (tx_valid[tx_port]) begin
					st_next.line_data = tx_data[tx_port]; // [R09]
				end else begin
					st_next.line_data = framer_pkg::LF_BLOCK;
				end
				if (tx_valid[tx_port] && st_reg.tx_lane == tx_fl
					&& st_reg.tx_meas[tx_fl] != framer_pkg::PMS) begin
					st_next.tx_meas[tx_fl] = st_reg.tx_meas[tx_fl] + 14'h0001;
				end
			end
			st_next.tx_lane = st_reg.tx_lane + 2'b01;
			if (st_reg.tx_lane == 2'b11) begin
				st_next.tx_blk = st_reg.tx_blk + 5'd1;
				if (32'(st_reg.tx_blk) == framer_pkg::ROW_BLKS - 1) begin
					st_next.tx_blk = 5'd0;
					st_next.tx_row = st_reg.tx_row + 7'd1; // [R01]
					if (32'(st_reg.tx_row) == framer_pkg::ROWS - 1) begin
						st_next.tx_multiframe_alignment_byte = st_reg.tx_multiframe_alignment_byte + 8'h01;
						if (st_reg.tx_multiframe_alignment_byte[1:0] == 2'b11) begin
							for (int l = 0; l < framer_pkg::LANES; l++) begin
								st_next.tx_cm_cur[l] = st_reg.tx_cm_nxt[l]; // [R16] [R23]
								st_next.tx_cm_nxt[l] = st_reg.tx_meas[l];
								st_next.tx_meas[l] = 14'h0000;
								st_next.tx_acc[l] = 14'h0000; // [R15]
							end
						end
					end
				end
			end
		end

		// receive: align, pull overhead, demap into ports
		st_next.rx_valid = 4'h0;
		if (rx_line_valid) begin
			if (rx_line_sof) begin
				st_next.rx_sync = 1'b1;
			end
			if (!rx_pay && rx_blk_c == 5'd3) begin
				st_next.rx_blk3[rx_lane_c] = rx_line_data;
			end
			if (!rx_pay && rx_blk_c == 5'd4) begin
				st_next.rx_msi[rx_lane_c] = get_byte(rx_oh, framer_pkg::OHB_MSI);
				st_next.rx_crc_bad[rx_lane_c] = rx_crc8 != get_byte(rx_oh, framer_pkg::OHB_JC3);
				if (rx_crc8 == get_byte(rx_oh, framer_pkg::OHB_JC3)) begin
					st_next.rx_cm_nxt[rx_lane_c] = {rx_jc1, rx_jc2[7:2]}; // [R20]
				end
				if (rx_crc4 == get_byte(rx_oh, framer_pkg::OHB_JC5) >> 4) begin
					st_next.rx_cnd_nxt[rx_lane_c] = rx_jc4[7:1];
				end
				if (rx_lane_c == 2'b00) begin
					st_next.rx_multiframe_alignment_byte = get_byte(rx_oh, framer_pkg::OHB_MULTIFRAME_ALIGNMENT_BYTE);
					st_next.rx_far_ld = rx_oh[framer_pkg::ROH_OFS + 8 * framer_pkg::OHB_STAT
						+ 7 - framer_pkg::STAT_LD];
					st_next.rx_far_flt = rx_oh[framer_pkg::ROH_OFS + 8 * framer_pkg::OHB_STAT
						+ 7 - framer_pkg::STAT_FLT];
				end
			end
			if (rx_pay) begin
				st_next.rx_acc[rx_lane_c] = rx_step[13:0];
				if (rx_step[14]) begin
					st_next.rx_valid[rx_port] = 1'b1;
					st_next.rx_data[rx_port] = (st_reg.rx_crc_bad[rx_fl] || !st_reg.rx_sync) ?
						framer_pkg::LF_BLOCK : rx_line_data; // [R22]
				end
				if (st_reg.ctrl[framer_pkg::CTRL_PRBS_CHK]) begin
					st_next.prbs_rx = prbs_seed(rx_line_data);
					if (rx_line_data != prbs_chk_v[256:0] && st_next.prbs_err != 16'hFFFF) begin
						st_next.prbs_err = st_next.prbs_err + 16'h0001;
					end
				end
			end
			st_next.rx_lane = rx_lane_c + 2'b01;
			st_next.rx_blk = rx_blk_c;
			st_next.rx_row = rx_row_c;
			if (rx_lane_c == 2'b11) begin
				st_next.rx_blk = rx_blk_c + 5'd1;
				if (32'(rx_blk_c) == framer_pkg::ROW_BLKS - 1) begin
					st_next.rx_blk = 5'd0;
					st_next.rx_row = rx_row_c + 7'd1;
					if (32'(rx_row_c) == framer_pkg::ROWS - 1 && st_next.rx_multiframe_alignment_byte[1:0] == 2'b11) begin
						for (int l = 0; l < framer_pkg::LANES; l++) begin
							st_next.rx_cm_cur[l] = st_reg.rx_cm_nxt[l]; // [R23]
							st_next.rx_cnd_cur[l] = st_reg.rx_cnd_nxt[l];
							st_next.rx_acc[l] = 14'h0000;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.ctrl <= framer_pkg::CTRL_RST;
			st_reg.msi_cfg <= framer_pkg::MSI_RST;
			st_reg.cnd_cfg <= framer_pkg::CND_RST;
			st_reg.prbs_tx <= '1; // zero seed would lock the pattern at zero [R22]
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata     = st_reg.prdata;
	assign pready     = psel & penable;
	assign pslverr    = psel & penable & st_reg.perr;
	assign line_data  = st_reg.line_data;
	assign line_valid = st_reg.line_valid;
	assign line_sof   = st_reg.line_sof;
	assign rx_data    = st_reg.rx_data;
	assign rx_valid   = st_reg.rx_valid;
endmodule // coherent_line_gmp_framer

// ===== framer_pkg.sv
// Purpose: shared constants for the line frame builder and its register map
// Assumes: one 257-bit block moves per line tick, four 100G tributary lanes
// Notes:   byte offsets address the 40-byte overhead chunk as 4 rows of 10
package framer_pkg;
	localparam int BLK_W       = 257;
	localparam int LANES       = 4;
	localparam int ROWS        = 128;
	localparam int ROW_BLKS    = 20;
	localparam int HDR_BLKS    = 5;
	localparam int PAY_BLKS    = ROWS * ROW_BLKS - HDR_BLKS;
	localparam int AM_MARKERS  = 4;
	localparam int AM_BITS     = 120;
	localparam int OH_START    = 960;
	localparam int OH_BYTES    = 40;
	localparam int OH_ROW_BYTES = 10;
	localparam int XPAD_BITS   = 5;
	localparam int HDR_BITS    = OH_START + OH_BYTES * 8 + XPAD_BITS;
	localparam int ROH_OFS     = OH_START - 3 * BLK_W;
	localparam logic [13:0] PMS = 14'h27EC;

	localparam int OHB_MULTIFRAME_ALIGNMENT_BYTE = 0;
	localparam int OHB_STAT = 1;
	localparam int OHB_GID  = 2;
	localparam int OHB_PID  = 3;
	localparam int OHB_JC4  = 8;
	localparam int OHB_JC1  = 9;
	localparam int OHB_JC5  = 18;
	localparam int OHB_JC2  = 19;
	localparam int OHB_JC6  = 28;
	localparam int OHB_JC3  = 29;
	localparam int OHB_MSI  = (4 - 1) * OH_ROW_BYTES + (5 - 1);
	localparam int STAT_LD  = 7;
	localparam int STAT_RD  = 6;
	localparam int STAT_FLT = 5;

	localparam logic [7:0] CRC8_POLY = 8'h07;
	localparam logic [3:0] CRC4_POLY = 4'h3;
	localparam logic [119:0] AM_PATTERN = 120'h9A_4A26_B665_B5D9_D9FE_8E0C_2600_C1;
	localparam logic [256:0] LF_BLOCK = {1'b1, {4{64'h0200_0000_0100_009C}}};

	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_MSI_CFG  = 8'h04;
	localparam logic [7:0] REG_CND_CFG  = 8'h08;
	localparam logic [7:0] REG_STATUS   = 8'h0C;
	localparam logic [7:0] REG_RX_MSI   = 8'h10;
	localparam logic [7:0] REG_PRBS_ERR = 8'h14;
	localparam logic [3:0] REG_RX_CM_HI = 4'h2;
	localparam logic [3:0] REG_TX_CM_HI = 4'h3;
	localparam int CTRL_TX_EN    = 0;
	localparam int CTRL_PRBS_GEN = 1;
	localparam int CTRL_PRBS_CHK = 2;
	localparam int CTRL_LD       = 3;
	localparam int CTRL_GID_LSB  = 8;

	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] MSI_1X400 = 32'hC0C0_C0C0;
	localparam logic [31:0] MSI_2X200 = 32'hC1C1_C0C0;
	localparam logic [31:0] MSI_4X100 = 32'hC0C1_C2C3;
	localparam logic [31:0] MSI_RST   = MSI_4X100;
	localparam logic [6:0]  CND_RST   = 7'h00;
endpackage

// ===== framer_props.sv
// Purpose: port checks for the line frame builder
// Assumes: single clock, LINE_DIV at its default
// Notes:   ctrl_q mirrors CTRL bits 1:0, the transmit enable and the pattern generator enable
`timescale 1ns/1ns
module framer_props (
	input wire logic              clock,
	input wire logic              sys_rst,
	input wire logic [7:0]        paddr,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [3:0][256:0] tx_data,
	input wire logic [3:0]        tx_valid,
	input wire logic [3:0]        tx_ready,
	input wire logic [256:0]      line_data,
	input wire logic              line_valid,
	input wire logic              line_sof,
	input wire logic              rx_line_valid,
	input wire logic [3:0]        rx_valid
);
	logic [1:0]  ctrl_q;
	logic [31:0] vcnt;
	logic        sof_seen;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_q   <= 2'h0;
			vcnt     <= 32'h0;
			sof_seen <= 1'h0;
		end else begin
			if (psel && penable && pready && pwrite && paddr == framer_pkg::REG_CTRL)
				ctrl_q <= pwdata[1:0];
			if (line_sof)
				vcnt <= 32'h1;
			else if (line_valid)
				vcnt <= vcnt + 32'h1;
			if (line_sof)
				sof_seen <= 1'h1;
		end
	end
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	a_apb_ready: assert property (psel && penable |-> pready)
		else $error("pready missing in access phase");
	a_apb_misalign: assert property (psel && !penable && paddr[1:0] != 2'h0 ##1 penable |-> pslverr)
		else $error("no error on misaligned address");
	a_sof_marker: assert property (line_sof |-> line_valid &&
		line_data[119:0] == framer_pkg::AM_PATTERN)
		else $error("frame start without marker");
	a_sof_period: assert property (line_sof && sof_seen |-> vcnt == 32'h2800)
		else $error("frame length wrong");
	a_hdr_no_take: assert property (line_sof |-> $past(tx_ready) == 4'h0)
		else $error("host block taken in header slot");
	a_ready_enable: assert property (tx_ready != 4'h0 |-> ctrl_q == 2'h1)
		else $error("ready while transmit disabled");
	a_ready_onehot: assert property ($onehot0(tx_ready))
		else $error("two ports served in one tick");
	a_take_line: assert property ((tx_ready & tx_valid) != 4'h0 |=> line_valid)
		else $error("taken block not sent");
	a_take_data: assert property (tx_ready[0] && tx_valid[0] |=> line_data == $past(tx_data[0]))
		else $error("sent block differs from host block");
	a_rx_after_line: assert property (rx_valid != 4'h0 |-> $past(rx_line_valid))
		else $error("receive output without line block");
	c_frame: cover property (line_sof);
	c_take: cover property (tx_ready[3] && tx_valid[3]);
	c_rx: cover property (rx_valid[0]);
	c_err: cover property (pslverr);
endmodule // framer_props

// ===== host_loop_model.sv
// Purpose: four host ports plus a line loopback in place of the FEC
// Assumes: hosts always have a block unless gap holds port 3 off
// Notes:   block = port number and a running sequence number
`timescale 1ns/1ns
module host_loop_model (
	input wire logic              clock,
	input wire logic              sys_rst,
	input wire logic              gap,
	input wire logic [3:0]        tx_ready,
	output logic [3:0]            tx_valid,
	output logic [3:0][256:0]     tx_data,
	input wire logic [256:0]      line_data,
	input wire logic              line_valid,
	input wire logic              line_sof,
	output logic [256:0]          rx_line_data,
	output logic                  rx_line_valid,
	output logic                  rx_line_sof
);
	logic [3:0][23:0] seq;
	always_ff @(posedge clock) begin
		for (int p = 0; p < 4; p++) begin
			if (sys_rst)
				seq[p] <= 24'h000001;
			else if (tx_ready[p] && tx_valid[p])
				seq[p] <= seq[p] + 24'h000001;
		end
	end
	always_comb begin
		for (int p = 0; p < 4; p++)
			tx_data[p] = {225'h0, 8'(p), seq[p]};
	end
	// all hosts share one clock, zero offset
	assign tx_valid      = gap ? 4'h7 : 4'hF;
	assign rx_line_valid = line_valid;
	assign rx_line_sof   = line_sof;
	// idle line shows inverted data, never a stale copy
	assign rx_line_data  = line_valid ? line_data : ~line_data;
endmodule // host_loop_model

// ===== jc_crc_unit.sv
// Purpose: check codes for the justification bytes
// Assumes: count and indicator bits arrive most significant first
// Notes:   purely combinational, used once on transmit and once on receive
`timescale 1ns/1ns
module jc_crc_unit (
	input  logic [15:0] cm_field,
	input  logic [6:0]  cnd_field,
	output logic [7:0]  crc8_out,
	output logic [3:0]  crc4_out
);
	always_comb begin
		logic [7:0] c8;
		logic [3:0] c4;
		logic       fb;
		c8 = 8'h00;
		c4 = 4'h0;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			fb = c8[7] ^ cm_field[i];
			c8 = {c8[6:0], 1'b0};
			if (fb) begin
				c8 = c8 ^ framer_pkg::CRC8_POLY; // [R24]
			end
		end
		for (int i = 6; i >= 0; i--) begin
			fb = c4[3] ^ cnd_field[i];
			c4 = {c4[2:0], 1'b0};
			if (fb) begin
				c4 = c4 ^ framer_pkg::CRC4_POLY; // [R18]
			end
		end
		crc8_out = c8;
		crc4_out = c4;
	end
endmodule // jc_crc_unit

// ===== testbench.sv
// Purpose: register, frame, stuffing and loopback tests of the frame builder
// Assumes: LINE_DIV 1, counts reach the line two four-frame sets after reset
// Notes:   run is about 83000 cycles
`timescale 1ns/1ns
module testbench;
	logic              clock;
	logic              sys_rst;
	logic [7:0]        paddr;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [3:0][256:0] tx_data;
	logic [3:0]        tx_valid;
	logic [3:0]        tx_ready;
	logic [256:0]      line_data;
	logic              line_valid;
	logic              line_sof;
	logic [256:0]      rx_line_data;
	logic              rx_line_valid;
	logic              rx_line_sof;
	logic              fec_degrade;
	logic [3:0][256:0] rx_data;
	logic [3:0]        rx_valid;
	logic              gap;
	logic              rx_chk;
	logic [3:0][23:0]  rx_seq;
	logic [31:0]       q;
	logic              e;
	logic [31:0]       msi_tab [3];
	int                n_fail;
	int                cmp_count;
	int                n_sof;
	int                k;
	coherent_line_gmp_framer #(.LINE_DIV(8'h01)) uut (.clock, .sys_rst, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .tx_data, .tx_valid,
		.tx_ready, .line_data, .line_valid, .line_sof, .rx_line_data, .rx_line_valid,
		.rx_line_sof, .fec_degrade, .rx_data, .rx_valid);
	host_loop_model hosts (.clock, .sys_rst, .gap, .tx_ready, .tx_valid, .tx_data,
		.line_data, .line_valid, .line_sof, .rx_line_data, .rx_line_valid, .rx_line_sof);
	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end
	task automatic end_sim;
		if (n_fail == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [256:0] seen, input logic [256:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel    <= 1'h1;
		penable <= 1'h0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 16);
		q = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		chk("apb answer", pready, 1'h1);
	endtask
	task automatic wait_sof(input int n);
		int t;
		t = n_sof + n;
		for (int g = 0; g < 100000 && n_sof < t; g++)
			@(posedge clock);
	endtask
	always @(posedge clock) begin
		if (line_sof)
			n_sof++;
		for (int p = 0; p < 4; p++)
			if (rx_chk && rx_valid[p] === 1'h1) begin
				chk("rx block", rx_data[p], {225'h0, 8'(p), rx_seq[p]});
				rx_seq[p] = rx_seq[p] + 24'h000001;
			end
	end
	initial begin
		repeat (100000) @(posedge clock);
		n_fail++;
		end_sim;
	end
	initial begin
		n_fail = 0;
		cmp_count = 0;
		n_sof = 0;
		rx_seq = {4{24'h000001}};
		rx_chk = 1'h1;
		gap = 1'h0;
		fec_degrade = 1'h0;
		sys_rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		msi_tab = '{framer_pkg::MSI_1X400, framer_pkg::MSI_2X200, framer_pkg::MSI_4X100};
		repeat (20) @(posedge clock);
		sys_rst <= 1'h0;
		apb(framer_pkg::REG_CTRL, 1'h0, 32'h0);
		chk("ctrl reset", q, framer_pkg::CTRL_RST);
		apb(framer_pkg::REG_MSI_CFG, 1'h0, 32'h0);
		chk("slot id reset", q, framer_pkg::MSI_RST);
		apb(framer_pkg::REG_CND_CFG, 1'h0, 32'h0);
		chk("residual reset", q, {25'h0, framer_pkg::CND_RST});
		apb(8'h30, 1'h0, 32'h0);
		chk("tx count reset", q, 32'h0);
		for (int i = 0; i < 2; i++) begin
			apb(i == 0 ? 8'h18 : 8'h02, 1'h0, 32'h0);
			chk("bad address error", e, 1'h1);
			chk("bad address data", q, 32'h0);
		end
		apb(framer_pkg::REG_CTRL, 1'h1, 32'h0000_AB01);
		apb(framer_pkg::REG_CTRL, 1'h0, 32'h0);
		chk("ctrl", q, 32'h0000_AB01);
		apb(framer_pkg::REG_CND_CFG, 1'h1, 32'h0000_005A);
		fec_degrade <= 1'h1;
		wait_sof(1);
		k = 0;
		for (int g = 0; g < 1000 && k < 100; g++) begin
			@(posedge clock);
			if (line_valid)
				k++;
		end
		chk("stuff block", line_data, 257'h0);
		for (int i = 0; i < 3; i++) begin
			apb(framer_pkg::REG_MSI_CFG, 1'h1, msi_tab[i]);
			wait_sof(2);
			apb(framer_pkg::REG_RX_MSI, 1'h0, 32'h0);
			chk("rx slot id", q, msi_tab[i]);
		end
		apb(framer_pkg::REG_STATUS, 1'h0, 32'h0);
		chk("status", q & 32'h0000_003F, 32'h0000_0030);
		wait_sof(9 - n_sof);
		repeat (50) @(posedge clock);
		apb(8'h30, 1'h0, 32'h0);
		chk("tx count", q, {18'h0, framer_pkg::PMS});
		apb(8'h20, 1'h0, 32'h0);
		chk("rx count", q, {9'h0, 7'h5A, 2'h0, framer_pkg::PMS});
		repeat (400) @(posedge clock);
		rx_chk <= 1'h0;
		gap <= 1'h1;
		@(posedge clock);
		for (int g = 0; g < 400 && tx_ready[3] !== 1'h1; g++)
			@(posedge clock);
		@(posedge clock);
		chk("local fault block", line_data, framer_pkg::LF_BLOCK);
		apb(framer_pkg::REG_CTRL, 1'h1, 32'h0000_AB07);
		repeat (200) @(posedge clock);
		apb(framer_pkg::REG_PRBS_ERR, 1'h1, 32'h0);
		repeat (200) @(posedge clock);
		apb(framer_pkg::REG_PRBS_ERR, 1'h0, 32'h0);
		chk("prbs errors", q, 32'h0);
		chk("prbs active", line_data == 257'h0, 1'h0);
		end_sim;
	end
endmodule // testbench
bind coherent_line_gmp_framer framer_props u_props (.clock, .sys_rst, .paddr, .psel, .penable,
	.pwrite, .pwdata, .pready, .pslverr, .tx_data, .tx_valid, .tx_ready, .line_data,
	.line_valid, .line_sof, .rx_line_valid, .rx_valid);
